// ---- src/bul_bank_unbalance_locator.sv ----
`timescale 1ns/1ps
// double-wye bank unbalance stages with element failure location
module bul_bank_unbalance_locator
	import bul_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS
)
(
	// clock and reset
	input  wire logic           clk,
	input  wire logic           reset_n,
	// phasor front end
	input  wire logic           sample_valid,
	input  bul_phasor_type      residual_first,
	input  bul_phasor_type      residual_second,
	input  bul_phasor_type      calculated_residual_input,
	input  bul_phasor_type      l1_unit,
	// settings
	input  wire logic [1:0]     input_select,
	input  wire logic [1:0][1:0] compensation_select,
	input  wire logic [1:0][15:0] pickup_setting,
	input  wire logic [1:0][15:0] delay_setting,
	input  bul_event_type [1:0] event_enable,
	input  wire logic [7:0]     allowed_failures,
	// commands
	input  wire logic           phasor_capture_trigger,
	input  wire logic           location_clear,
	input  wire logic           counter_clear,
	// live values
	output logic [15:0]         raw_unbalance_magnitude,
	output logic [1:0][23:0]    compensated_unbalance_ma,
	output logic [1:0]          stage_start,
	output logic [1:0]          stage_trip,
	output bul_event_type [1:0] stage_event,
	output logic [1:0][7:0]     elapsed_delay_ratio,
	output logic [1:0][15:0]    cumulative_start_count,
	output logic [1:0][15:0]    cumulative_trip_count,
	// captured values
	output bul_phasor_type      saved_reference,
	output logic [15:0]         saved_unbalance_magnitude,
	output logic [15:0]         saved_unbalance_angle,
	output logic [15:0]         located_change_magnitude,
	output logic [15:0]         located_change_angle,
	// failure counters, index phase*2+branch
	output logic [5:0][7:0]     element_failures,
	output logic [10:0]         total_failures
);
	// whole state of the block
	typedef struct packed {
		bul_phasor_type       rel;
		logic                 p1;
		logic [23:0]          tick_cnt;
		logic                 tick;
		bul_stage_type [1:0]  stg;
		logic [5:0][7:0]      fail;
		logic [10:0]          total;
		logic [15:0]          raw_mag;
		bul_job_type          job;
		logic                 save_pend;
		logic                 loc_pend;
		logic                 cstart;
		bul_phasor_type       save_vec;
		bul_phasor_type       loc_vec;
		bul_phasor_type       saved_ref;
		logic [15:0]          saved_mag;
		logic [15:0]          saved_ang;
		logic [15:0]          loc_mag;
		logic [15:0]          loc_ang;
	} bul_state_type;

	bul_state_type  st;
	bul_state_type  next_st;
	bul_phasor_type cordic_vec;  // phasor handed to the angle unit
	logic           cordic_done; // angle unit finished
	logic [15:0]    cordic_mag;  // its magnitude
	logic [15:0]    cordic_ang;  // its angle

	// cheap magnitude: max plus three eighths of min
	function automatic logic [15:0] mag_est(
		input logic signed [16:0] re,
		input logic signed [16:0] im
	);
		logic [16:0] a;
		logic [16:0] b;
		logic [18:0] sum;
		a = re[16] ? 17'(-re) : 17'(re);
		b = im[16] ? 17'(-im) : 17'(im);
		if (a >= b) begin
			sum = 19'(a) + 19'(b >> 2) + 19'(b >> 3);
		end else begin
			sum = 19'(b) + 19'(a >> 2) + 19'(a >> 3);
		end
		mag_est = (sum > 19'(MAG_MAX)) ? MAG_MAX : sum[15:0];
	endfunction

	// sector of a change phasor, 60 degree steps from 0
	function automatic logic [2:0] sector(
		input logic signed [16:0] re,
		input logic signed [16:0] im
	);
		logic [16:0] a;
		logic [16:0] b;
		logic [32:0] t;
		a = re[16] ? 17'(-re) : 17'(re);
		b = im[16] ? 17'(-im) : 17'(im);
		t = 33'(a) * 33'(TAN30_Q14);
		if (33'(b) < (t >> UNIT_SHIFT)) begin
			sector = re[16] ? 3'h3 : 3'h0;
		end else if (!im[16]) begin
			sector = re[16] ? 3'h2 : 3'h1;
		end else begin
			sector = re[16] ? 3'h4 : 3'h5;
		end
	endfunction

	// angle unit works on the captured or located phasor
	assign cordic_vec = (st.job == JOB_LOC) ? st.loc_vec : st.save_vec;

	bul_cordic u_cordic (
		.clk       (clk),
		.reset_n   (reset_n),
		.start     (st.cstart),
		.vec_in    (cordic_vec),
		.done      (cordic_done),
		.magnitude (cordic_mag),
		.angle     (cordic_ang)
	);

	// next state
	always_comb begin
		bul_phasor_type     sel;
		bul_phasor_type     refp;
		logic signed [32:0] pr;
		logic signed [32:0] pi;
		logic signed [16:0] dre;
		logic signed [16:0] dim;
		logic [15:0]        m;
		logic [15:0]        pk;
		logic [15:0]        dl;
		logic [16:0]        acc_n;
		logic               comp_on;
		logic               loc;
		logic               rise;
		logic               expire;
		logic [2:0]         idx;
		sel = residual_second;
		refp = '0;
		pr = '0;
		pi = '0;
		dre = '0;
		dim = '0;
		m = '0;
		pk = '0;
		dl = '0;
		acc_n = '0;
		comp_on = 1'b0;
		loc = 1'b0;
		rise = 1'b0;
		expire = 1'b0;
		idx = '0;
		next_st = st;
		next_st.p1 = 1'b0;
		next_st.tick = 1'b0;
		next_st.cstart = 1'b0;

		// free running 0.01 s tick
		if (st.tick_cnt == 24'(TICK_CYCLES - 1)) begin
			next_st.tick_cnt = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 24'h000001;
		end

		// residual input choice
		case (input_select)
			SEL_IO1:  sel = residual_first;
			SEL_CALC: sel = calculated_residual_input;
			default:  sel = residual_second;
		endcase

		// turn residual into l1 reference frame
		pr = (33'(sel.re) * 33'(l1_unit.re)) + (33'(sel.im) * 33'(l1_unit.im));
		pi = (33'(sel.im) * 33'(l1_unit.re)) - (33'(sel.re) * 33'(l1_unit.im));
		if (sample_valid) begin
			next_st.rel.re = pr[UNIT_SHIFT+15:UNIT_SHIFT];
			next_st.rel.im = pi[UNIT_SHIFT+15:UNIT_SHIFT];
			next_st.p1 = 1'b1;
		end

		// raw magnitude including natural unbalance
		if (st.p1) begin
			next_st.raw_mag = mag_est(17'(st.rel.re), 17'(st.rel.im));
		end

		// element counter clear, later increments still count
		if (location_clear) begin
			next_st.fail = '0;
			next_st.total = '0;
		end

		// both stages
		for (int s = 0; s < 2; s++) begin
			// settings, out of range falls back to default
			pk = pickup_setting[s];
			if (pk < PICKUP_MIN || pk > PICKUP_MAX) begin
				pk = PICKUP_DEFAULT[s];
			end
			dl = delay_setting[s];
			if (dl < DELAY_MIN || dl > DELAY_MAX) begin
				dl = DELAY_DEFAULT[s];
			end
			comp_on = compensation_select[s] != MODE_OFF;
			loc = (s == STAGE_LOC) && (compensation_select[s] == MODE_LOCATION);
			next_st.stg[s].ev = '0;

			// compensated phasor and start decision
			if (st.p1) begin
				refp = comp_on ? st.stg[s].stored : '0;
				dre = 17'(st.rel.re) - 17'(refp.re);
				dim = 17'(st.rel.im) - 17'(refp.im);
				m = mag_est(dre, dim);
				next_st.stg[s].diff_re = dre;
				next_st.stg[s].diff_im = dim;
				next_st.stg[s].mag = m;
				next_st.stg[s].amps = 24'(m) * 24'(IO_NOMINAL_AMP);
				next_st.stg[s].start = m > 16'(pk * PICKUP_TO_MAG);
			end
			rise = next_st.stg[s].start & ~st.stg[s].start;

			// definite delay timer and elapsed percentage
			if (rise) begin
				next_st.stg[s].pct = '0;
			end
			if (!next_st.stg[s].start) begin
				next_st.stg[s].timer = '0;
				next_st.stg[s].acc = '0;
				next_st.stg[s].trip = 1'b0;
			end else if (st.tick && st.stg[s].timer < dl) begin
				next_st.stg[s].timer = st.stg[s].timer + 16'h0001;
				// a short delay earns several percent per tick, the remainder carries over
				acc_n = 17'(st.stg[s].acc) + 17'(PERCENT_FULL);
				next_st.stg[s].acc = 16'(acc_n % 17'(dl));
				next_st.stg[s].pct = st.stg[s].pct + 8'(acc_n / 17'(dl));
			end
			expire = next_st.stg[s].start && (next_st.stg[s].timer == dl) && (st.stg[s].timer != dl);

			// delay expiry
			if (expire) begin
				next_st.stg[s].pct = PERCENT_FULL;
				if (!loc) begin
					next_st.stg[s].trip = 1'b1;
				end else begin
					// confirmed element failure, fold change into stored phasor
					next_st.stg[s].stored.re = 16'(17'(st.stg[s].stored.re) + next_st.stg[s].diff_re);
					next_st.stg[s].stored.im = 16'(17'(st.stg[s].stored.im) + next_st.stg[s].diff_im);
					next_st.loc_vec.re = 16'(next_st.stg[s].diff_re);
					next_st.loc_vec.im = 16'(next_st.stg[s].diff_im);
					next_st.loc_pend = 1'b1;
					idx = SECTOR_TO_COUNTER[sector(next_st.stg[s].diff_re, next_st.stg[s].diff_im)];
					if (next_st.fail[idx] != FAIL_MAX) begin
						next_st.fail[idx] = next_st.fail[idx] + 8'h01;
						next_st.total = next_st.total + 11'h001;
					end
					next_st.stg[s].diff_re = '0;
					next_st.stg[s].diff_im = '0;
					next_st.stg[s].mag = '0;
					next_st.stg[s].amps = '0;
					next_st.stg[s].start = 1'b0;
					next_st.stg[s].timer = '0;
					next_st.stg[s].acc = '0;
				end
			end

			// location stage trips on failure count only
			if (loc) begin
				next_st.stg[s].trip = next_st.total > 11'(allowed_failures);
			end

			// maskable events and cumulative counters
			rise = next_st.stg[s].start & ~st.stg[s].start;
			next_st.stg[s].ev.start_on = rise & event_enable[s].start_on;
			next_st.stg[s].ev.start_off = ~next_st.stg[s].start & st.stg[s].start
				& event_enable[s].start_off;
			next_st.stg[s].ev.trip_on = next_st.stg[s].trip & ~st.stg[s].trip
				& event_enable[s].trip_on;
			next_st.stg[s].ev.trip_off = ~next_st.stg[s].trip & st.stg[s].trip
				& event_enable[s].trip_off;
			if (counter_clear) begin
				next_st.stg[s].scnt = '0;
				next_st.stg[s].tcnt = '0;
			end
			if (rise) begin
				next_st.stg[s].scnt = next_st.stg[s].scnt + 16'h0001;
			end
			if (next_st.stg[s].trip & ~st.stg[s].trip) begin
				next_st.stg[s].tcnt = next_st.stg[s].tcnt + 16'h0001;
			end
		end

		// manual natural capture, both stages, wins over a same-cycle recompensation of the stored phasor
		if (phasor_capture_trigger) begin
			for (int s = 0; s < 2; s++) begin
				next_st.stg[s].stored = st.rel;
				next_st.stg[s].diff_re = '0;
				next_st.stg[s].diff_im = '0;
				next_st.stg[s].mag = '0;
				next_st.stg[s].amps = '0;
			end
			next_st.saved_ref = l1_unit;
			next_st.save_vec = st.rel;
			next_st.save_pend = 1'b1;
		end

		// angle job sequencer
		case (st.job)
			JOB_IDLE: begin
				if (st.save_pend) begin
					next_st.job = JOB_SAVE;
					next_st.cstart = 1'b1;
					next_st.save_pend = phasor_capture_trigger;
				end else if (st.loc_pend) begin
					next_st.job = JOB_LOC;
					next_st.cstart = 1'b1;
					next_st.loc_pend = next_st.loc_pend & ~st.loc_pend | expire;
				end
			end
			JOB_SAVE: begin
				if (cordic_done) begin
					next_st.saved_mag = cordic_mag;
					next_st.saved_ang = cordic_ang;
					next_st.job = JOB_IDLE;
				end
			end
			JOB_LOC: begin
				if (cordic_done) begin
					next_st.loc_mag = cordic_mag;
					next_st.loc_ang = cordic_ang;
					next_st.job = JOB_IDLE;
				end
			end
			default: begin
				next_st.job = JOB_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			compensated_unbalance_ma[s] = st.stg[s].amps;
			stage_start[s] = st.stg[s].start;
			stage_trip[s] = st.stg[s].trip;
			stage_event[s] = st.stg[s].ev;
			elapsed_delay_ratio[s] = st.stg[s].pct;
			cumulative_start_count[s] = st.stg[s].scnt;
			cumulative_trip_count[s] = st.stg[s].tcnt;
		end
	end

	assign raw_unbalance_magnitude = st.raw_mag;
	assign saved_reference = st.saved_ref;
	assign saved_unbalance_magnitude = st.saved_mag;
	assign saved_unbalance_angle = st.saved_ang;
	assign located_change_magnitude = st.loc_mag;
	assign located_change_angle = st.loc_ang;
	assign element_failures = st.fail;
	assign total_failures = st.total;
endmodule

// ---- src/bul_pkg.sv ----
package bul_pkg;
	// Behaviour
	// - natural capture only on explicit command
	// - capture stores unbalance and l1 phasors
	// - unbalance angles taken relative to l1
	// - compensated equals measured minus stored phasor
	// - report raw magnitude and compensated amperes
	// - start when compensated exceeds pickup setting
	// - only second stage offers location mode
	// - mode selectors off/on and off/normal/location
	// - location delay confirms failure, then recompensates
	// - recompensation leaves first stage untouched
	// - change angle picks one of six counters
	// - trip once total exceeds allowed failures
	// - clear command zeroes failure counters
	// - record magnitude, angle of located change
	// - elapsed delay reported as percentage
	// - report stored natural angle and magnitude
	// - input select first, second, calculated residual

	// clock and delay resolution
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 10_000_000; // 0.01 s delay step
	localparam int UNIT_SHIFT    = 14;         // l1 unit vector is Q1.14
	// stage indexes
	localparam int STAGE_COMP = 0;
	localparam int STAGE_LOC  = 1;
	// settings limits, pickup in 0.01 pu, delay in 0.01 s
	localparam logic [15:0] PICKUP_MIN = 16'h0001;
	localparam logic [15:0] PICKUP_MAX = 16'h07D0;
	localparam logic [1:0][15:0] PICKUP_DEFAULT = {16'h0014, 16'h000A};
	localparam logic [15:0] PICKUP_TO_MAG = 16'h000A; // 0.01 pu to 0.001 pu
	localparam logic [15:0] DELAY_MIN = 16'h0008;
	localparam logic [15:0] DELAY_MAX = 16'h7530;
	localparam logic [1:0][15:0] DELAY_DEFAULT = {16'h0064, 16'h0032};
	localparam logic [7:0]  PERCENT_FULL = 8'h64;
	localparam logic [7:0]  IO_NOMINAL_AMP = 8'h05; // amperes per pu
	localparam logic [15:0] MAG_MAX = 16'hFFFF;
	localparam logic [15:0] TAN30_Q14 = 16'h24F3;
	localparam logic [7:0]  FAIL_MAX = 8'hFF;
	// cordic, angles in 0.01 degree
	localparam int CORDIC_STEPS = 14;
	localparam logic [13:0][15:0] CORDIC_ATAN = {
		16'h0001, 16'h0001, 16'h0003, 16'h0006, 16'h000B, 16'h0016, 16'h002D,
		16'h005A, 16'h00B3, 16'h0166, 16'h02C9, 16'h057C, 16'h0A61, 16'h1194};
	localparam logic [16:0] ANGLE_HALF = 17'h04650;
	localparam logic [16:0] ANGLE_FULL = 17'h08CA0;
	localparam logic [17:0] CORDIC_GAIN = 18'h09B75; // 1/k in Q16
	localparam int CORDIC_GUARD = 4;                  // extra fraction bits inside the cordic
	localparam int CORDIC_SCALE = 20;                 // gain fraction plus guard bits
	localparam logic [39:0] CORDIC_ROUND = 40'h0000080000; // half lsb at that scale
	// sector 0..5 (60 degree steps) to counter index phase*2+branch
	localparam logic [5:0][2:0] SECTOR_TO_COUNTER = {
		3'h5, 3'h2, 3'h1, 3'h4, 3'h3, 3'h0};

	// residual input choice, zero selects second input
	typedef enum logic [1:0] {
		SEL_IO2 = 2'h0, SEL_IO1 = 2'h1, SEL_CALC = 2'h2
	} bul_input_type;
	// compensation mode
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0, MODE_ON = 2'h1, MODE_LOCATION = 2'h3
	} bul_mode_type;
	// angle job sequencer, gray along idle-save-locate
	typedef enum logic [1:0] {
		JOB_IDLE = 2'h0, JOB_SAVE = 2'h1, JOB_LOC = 2'h3
	} bul_job_type;

	// rectangular phasor, 0.001 pu per lsb
	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} bul_phasor_type;
	// stage event group
	typedef struct packed {
		logic start_on;
		logic start_off;
		logic trip_on;
		logic trip_off;
	} bul_event_type;
	// one protection stage
	typedef struct packed {
		bul_phasor_type     stored;
		logic signed [16:0] diff_re;
		logic signed [16:0] diff_im;
		logic [15:0]        mag;
		logic [23:0]        amps;
		logic               start;
		logic               trip;
		logic [15:0]        timer;
		logic [15:0]        acc;
		logic [7:0]         pct;
		logic [15:0]        scnt;
		logic [15:0]        tcnt;
		bul_event_type      ev;
	} bul_stage_type;
endpackage

// ---- src/bul_cordic.sv ----
`timescale 1ns/1ps
// vectoring cordic: magnitude and angle of one phasor
module bul_cordic
	import bul_pkg::*;
(
	// clock and reset
	input  wire logic    clk,
	input  wire logic    reset_n,
	// request
	input  wire logic    start,
	input  bul_phasor_type vec_in,
	// answer
	output logic         done,
	output logic [15:0]  magnitude,
	output logic [15:0]  angle
);
	// whole state of the unit
	typedef struct packed {
		logic               busy;
		logic [3:0]         step;
		logic signed [21:0] x;
		logic signed [21:0] y;
		logic [16:0]        z;
		logic               done;
		logic [15:0]        mag;
		logic [15:0]        ang;
	} bul_cordic_type;

	bul_cordic_type st;
	bul_cordic_type next_st;

	// one micro-rotation per cycle, guard bits keep shift truncation below one lsb
	always_comb begin
		logic signed [21:0] xn;
		logic signed [21:0] yn;
		logic signed [21:0] xs;
		logic signed [21:0] ys;
		logic [16:0]        zn;
		logic [39:0]        prod;
		xn = st.x;
		yn = st.y;
		xs = '0;
		ys = '0;
		zn = st.z;
		prod = '0;
		next_st = st;
		next_st.done = 1'b0;
		if (start) begin
			// fold left half plane onto the right, add guard bits
			next_st.busy = 1'b1;
			next_st.step = '0;
			next_st.x = vec_in.re[15] ? -(22'(vec_in.re) <<< CORDIC_GUARD) : 22'(vec_in.re) <<< CORDIC_GUARD;
			next_st.y = vec_in.re[15] ? -(22'(vec_in.im) <<< CORDIC_GUARD) : 22'(vec_in.im) <<< CORDIC_GUARD;
			next_st.z = vec_in.re[15] ? ANGLE_HALF : '0;
		end else if (st.busy) begin
			// shift magnitudes so a small negative y does not stick at minus one
			xs = st.x >>> st.step;
			ys = st.y[21] ? -((-st.y) >>> st.step) : st.y >>> st.step;
			if (!st.y[21]) begin
				xn = st.x + ys;
				yn = st.y - xs;
				zn = st.z + 17'(CORDIC_ATAN[st.step]);
			end else begin
				xn = st.x - ys;
				yn = st.y + xs;
				zn = st.z - 17'(CORDIC_ATAN[st.step]);
			end
			next_st.x = xn;
			next_st.y = yn;
			next_st.z = zn;
			next_st.step = st.step + 4'h1;
			if (st.step == 4'(CORDIC_STEPS - 1)) begin
				// remove cordic gain and guard bits with rounding, wrap angle to 0..359.99
				prod = 40'(xn[20:0]) * 40'(CORDIC_GAIN) + CORDIC_ROUND;
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.mag = 16'(prod >> CORDIC_SCALE);
				next_st.ang = zn[16] ? 16'(zn + ANGLE_FULL) : zn[15:0];
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;
	assign magnitude = st.mag;
	assign angle = st.ang;
endmodule

// ---- tb/bul_front_end_model.sv ----
`timescale 1ns/1ps
// phasor front end: one sample pulse every fourth cycle, l1 reference at angle zero
module bul_front_end_model
	import bul_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      reset_n,
	// values chosen by the bench
	input  bul_phasor_type first_in,
	input  bul_phasor_type second_in,
	// phasor outputs
	output logic           sample_valid,
	output bul_phasor_type residual_first,
	output bul_phasor_type residual_second,
	output bul_phasor_type calculated_residual_input,
	output bul_phasor_type l1_unit
);
	logic [1:0] phase_cnt; // sample cadence counter
	// launch a new phasor set with each pulse, hold it until the next
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_cnt       <= 2'h0;
			sample_valid    <= 1'b0;
			residual_first  <= '0;
			residual_second <= '0;
		end else begin
			phase_cnt    <= phase_cnt + 2'h1;
			sample_valid <= (phase_cnt == 2'h3);
			if (phase_cnt == 2'h3) begin
				residual_first  <= first_in;
				residual_second <= second_in;
			end
		end
	end
	// calculated residual is the sum of both inputs
	assign calculated_residual_input = '{re: residual_first.re + residual_second.re,
		im: residual_first.im + residual_second.im};
	// unity l1 reference keeps relative angles equal to absolute ones
	assign l1_unit = '{re: 16'sh4000, im: 16'sh0000};
endmodule

// ---- tb/bul_bank_unbalance_locator_assertions.sv ----
`timescale 1ns/1ps
// protocol checks on the unbalance stage ports
module bul_bank_unbalance_locator_assertions
	import bul_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            reset_n,
	// settings and commands
	input  wire logic [1:0][1:0] compensation_select,
	input  bul_event_type [1:0]  event_enable,
	input  wire logic [7:0]      allowed_failures,
	input  wire logic            phasor_capture_trigger,
	input  wire logic            location_clear,
	input  wire logic            counter_clear,
	// watched outputs
	input  wire logic [1:0][23:0] compensated_unbalance_ma,
	input  wire logic [1:0]      stage_start,
	input  wire logic [1:0]      stage_trip,
	input  bul_event_type [1:0]  stage_event,
	input  wire logic [1:0][7:0] elapsed_delay_ratio,
	input  wire logic [1:0][15:0] cumulative_start_count,
	input  wire logic [1:0][15:0] cumulative_trip_count,
	input  bul_phasor_type       saved_reference,
	input  wire logic [5:0][7:0] element_failures,
	input  wire logic [10:0]     total_failures
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	chk_start_event: assert property ($rose(stage_start[0]) && event_enable[0].start_on |-> stage_event[0].start_on)
		else $error("start event missing");
	chk_trip_event: assert property ($fell(stage_trip[0]) && event_enable[0].trip_off |-> stage_event[0].trip_off)
		else $error("trip off event missing");
	chk_trip_full: assert property ($rose(stage_trip[0]) |-> ##[0:1] elapsed_delay_ratio[0] == PERCENT_FULL)
		else $error("ratio not full at trip");
	chk_trip_start: assert property (stage_trip[0] |-> stage_start[0])
		else $error("trip without start");
	chk_loc_trip: assert property (stage_trip[1] |-> total_failures > {3'h0, allowed_failures})
		else $error("location trip below allowance");
	chk_loc_clear: assert property (location_clear && !stage_start[1] |=> total_failures == '0 && element_failures == '0)
		else $error("failure counters not cleared");
	chk_cnt_clear: assert property (counter_clear && stage_start == 2'h0 |=>
		cumulative_start_count[0] == 16'($rose(stage_start[0]))
		&& cumulative_start_count[1] == 16'($rose(stage_start[1]))
		&& cumulative_trip_count[0] == 16'($rose(stage_trip[0]))
		&& cumulative_trip_count[1] == 16'($rose(stage_trip[1])))
		else $error("cumulative counters not cleared");
	chk_capture_zero: assert property (phasor_capture_trigger && compensation_select[0] == 2'h1 |=>
		compensated_unbalance_ma[0] == '0)
		else $error("compensated not zero after capture");
	chk_stored_hold: assert property (!phasor_capture_trigger |=> $stable(saved_reference))
		else $error("stored reference moved without capture");
endmodule

bind bul_bank_unbalance_locator bul_bank_unbalance_locator_assertions u_chk (.clk, .reset_n,
	.compensation_select, .event_enable, .allowed_failures, .phasor_capture_trigger, .location_clear,
	.counter_clear, .compensated_unbalance_ma, .stage_start, .stage_trip, .stage_event, .elapsed_delay_ratio,
	.cumulative_start_count, .cumulative_trip_count, .saved_reference, .element_failures, .total_failures);

// ---- tb/bul_bank_unbalance_locator_tb.sv ----
`timescale 1ns/1ps
// bench: capture, two element failures, clears, mode and input selection
module bul_bank_unbalance_locator_tb
	import bul_pkg::*;
;
	logic clk, reset_n, sample_valid, capture, loc_clear, cnt_clear;
	bul_phasor_type first_in, second_in, res1, res2, res_calc, l1;
	logic [1:0] input_select, stage_start, stage_trip;
	logic [1:0][1:0] comp_sel;
	logic [1:0][15:0] pickup, delay, s_cnt, t_cnt;
	logic [1:0][23:0] comp_ma;
	logic [1:0][7:0] ratio;
	logic [15:0] raw_mag, sav_mag, sav_ang, loc_mag, loc_ang;
	logic [5:0][7:0] fails;
	logic [10:0] total;
	int n_mismatch, total_checks;

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	bul_front_end_model fe (.clk(clk), .reset_n(reset_n), .first_in(first_in), .second_in(second_in),
		.sample_valid(sample_valid), .residual_first(res1), .residual_second(res2),
		.calculated_residual_input(res_calc), .l1_unit(l1));

	bul_bank_unbalance_locator #(.TICK_CYCLES(10)) dut (.clk(clk), .reset_n(reset_n),
		.sample_valid(sample_valid), .residual_first(res1), .residual_second(res2),
		.calculated_residual_input(res_calc), .l1_unit(l1), .input_select(input_select),
		.compensation_select(comp_sel), .pickup_setting(pickup), .delay_setting(delay),
		.event_enable({4'hF, 4'hF}), .allowed_failures(8'h01), .phasor_capture_trigger(capture),
		.location_clear(loc_clear), .counter_clear(cnt_clear), .raw_unbalance_magnitude(raw_mag),
		.compensated_unbalance_ma(comp_ma), .stage_start(stage_start), .stage_trip(stage_trip),
		.stage_event(), .elapsed_delay_ratio(ratio), .cumulative_start_count(s_cnt),
		.cumulative_trip_count(t_cnt), .saved_reference(), .saved_unbalance_magnitude(sav_mag),
		.saved_unbalance_angle(sav_ang), .located_change_magnitude(loc_mag),
		.located_change_angle(loc_ang), .element_failures(fails), .total_failures(total));

	// final verdict, the only place the run ends
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// compare one value
	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// bounded wait: 0 location start, 1 compensated trip, 2 and up failure total of what-1
	task automatic wait_until(input int what);
		int n;
		n = 0;
		while (n < 400 && !(what == 0 ? stage_start[1] === 1'b1 : what == 1 ? stage_trip[0] === 1'b1 :
			total === 11'(what - 1))) begin
			@(posedge clk);
			n++;
		end
		if (n == 400) begin
			n_mismatch++;
			$display("Error wait %0d expected 1 seen 0", what);
			test_done();
		end
	endtask

	// idle cycles for the sample pipeline and angle solver to settle
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		reset_n = 1'b0;
		capture = 1'b0;
		loc_clear = 1'b0;
		cnt_clear = 1'b0;
		input_select = 2'h0;
		comp_sel = {2'h3, 2'h1};
		pickup = {16'h0014, 16'h000A};
		delay = {16'h0008, 16'h0008};
		first_in = '{re: 16'sh0000, im: 16'sh0000};
		second_in = '{re: 16'sh03E8, im: 16'sh0000};
		n_mismatch = 0;
		total_checks = 0;
		idle(10);
		reset_n <= 1'b1;
		idle(12);
		check_val("raw magnitude", 24'h3E8, raw_mag);
		capture <= 1'b1;
		idle(1);
		capture <= 1'b0;
		idle(2);
		check_val("compensated stage0", 24'h0, comp_ma[0]);
		check_val("compensated stage1", 24'h0, comp_ma[1]);
		idle(40);
		check_val("saved magnitude", 24'h1, (sav_mag >= 16'h03E7 && sav_mag <= 16'h03E9));
		check_val("saved angle", 24'h1, (sav_ang <= 16'h0005 || sav_ang >= 16'h8C9B));
		$display("test capture done");
		second_in <= '{re: 16'sh0514, im: 16'sh0000};
		wait_until(0);
		idle(1);
		check_val("start stage0", 24'h1, stage_start[0]);
		check_val("raw after fault", 24'h514, raw_mag);
		check_val("amperes stage0", 24'h5DC, comp_ma[0]);
		wait_until(1);
		idle(40);
		check_val("ratio stage0", 24'h64, ratio[0]);
		check_val("failures total", 24'h1, total);
		check_val("failures phase1_branch1_failures", 24'h1, fails[0]);
		check_val("location trip", 24'h0, stage_trip[1]);
		check_val("amperes stage1", 24'h0, comp_ma[1]);
		check_val("amperes kept", 24'h5DC, comp_ma[0]);
		check_val("located magnitude", 24'h1, (loc_mag >= 16'h012B && loc_mag <= 16'h012D));
		check_val("located angle", 24'h1, (loc_ang <= 16'h0005 || loc_ang >= 16'h8C9B));
		$display("test first failure done");
		second_in <= '{re: 16'sh03E8, im: 16'sh0000};
		wait_until(3);
		idle(4);
		check_val("failures l1 b2", 24'h1, fails[1]);
		check_val("location trip", 24'h1, stage_trip[1]);
		check_val("trip released", 24'h0, stage_trip[0]);
		// one rise before the natural capture, one at the element failure
		check_val("starts stage0", 24'h2, s_cnt[0]);
		check_val("trips stage0", 24'h1, t_cnt[0]);
		$display("test second failure done");
		loc_clear <= 1'b1;
		idle(1);
		loc_clear <= 1'b0;
		idle(2);
		check_val("total cleared", 24'h0, total);
		check_val("trip cleared", 24'h0, stage_trip[1]);
		cnt_clear <= 1'b1;
		idle(1);
		cnt_clear <= 1'b0;
		idle(2);
		check_val("starts cleared", 24'h0, s_cnt[1]);
		$display("test clears done");
		comp_sel[0] <= 2'h0;
		idle(12);
		check_val("uncompensated start", 24'h1, stage_start[0]);
		input_select <= 2'h1;
		idle(12);
		check_val("first input raw", 24'h0, raw_mag);
		input_select <= 2'h2;
		idle(12);
		check_val("calculated input raw", 24'h3E8, raw_mag);
		$display("test selection done");
		test_done();
	end
endmodule
